/* tx_list_status_word_tb_top.sv */
`timescale 1ns/1ps
`include "txsw_regs.svh"
module tx_list_status_word_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slow;
  logic req_valid, fwd_ptr_zero, frame_in_fifo, sw_wr_valid, sw_wr_ready;
  logic crc_append, prio_valid, chan_stopped;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] req_word, sw_wr_data, mem_word;
  logic [2:0] phy_tx_nibble_lines;
  int err_count, checks;
  txsw_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .req_valid, .req_word, .fwd_ptr_zero,
    .frame_in_fifo, .sw_wr_valid, .sw_wr_data, .sw_wr_ready, .crc_append,
    .phy_tx_nibble_lines, .prio_valid, .chan_stopped, .irq);
  txsw_host_model host (.pclk, .presetn, .sw_wr_valid, .sw_wr_data,
    .sw_wr_ready, .slow, .mem_word);
  // ---
  // helpers
  // ---
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task results();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20 && pready !== 1'b1)
    begin
      err_count++;
      results();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task frame(input logic last);
    logic [31:0] r;
    logic [15:0] w, e;
    int n;
    r = xs();
    apb(1'b1, `OFF_CTRL, {30'h0, r[25:24]});
    // bits 13,12 set, 11,10,8,7-3 clear; 15 and 14 left random
    w = {r[15:14], 2'b11, 2'b00, r[9], 6'h00, r[2:0]};
    slow <= r[20];
    req_valid <= 1'b1;
    req_word <= w;
    fwd_ptr_zero <= last;
    @(posedge pclk);
    req_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("crc_append", {31'h0, !w[9]}, crc_append);
    chk("prio_valid", {31'h0, r[25]}, prio_valid);
    chk("prio", r[25] ? w[2:0] : 3'h0, phy_tx_nibble_lines);
    frame_in_fifo <= 1'b1;
    @(posedge pclk);
    frame_in_fifo <= 1'b0;
    e = {w[15], 1'b1, w[13:12], last, w[10:8], 5'h00, w[2:0]};
    // sample on the falling edge, where the registered outputs are settled
    n = 0;
    @(negedge pclk);
    while (!(sw_wr_valid && sw_wr_ready) && n < 30)
    begin
      @(negedge pclk);
      n++;
    end
    if (n == 30)
    begin
      err_count++;
      results();
    end
    chk("sw_wr_data", e, sw_wr_data);
    @(posedge pclk);
    @(negedge pclk);
    chk("stopped", {31'h0, last}, chan_stopped);
    chk("mem_word", e, mem_word);
    @(posedge pclk);
  endtask
  // ---
  // sequence
  // ---
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    repeat (100000) @(posedge pclk);
    err_count++;
    results();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, req_valid, fwd_ptr_zero} = 6'h00;
    {frame_in_fifo, slow, paddr, pwdata, req_word} = 62'h0;
    seed = 32'hD2;
    err_count = 0;
    checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 40; i++)
      frame(i % 8 == 7);
    chk("irq_masked", 32'h0, irq);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, `OFF_INT_EN, 32'h3);
    chk("irq_on", 32'h1, irq);
    apb(1'b0, `OFF_INT_STAT, 32'h0);
    chk("int_stat", 32'h3, rd);
    apb(1'b1, `OFF_INT_CLR, 32'h3);
    chk("irq_off", 32'h0, irq);
    results();
  end
endmodule

/* txsw_compose.sv */
`timescale 1ns/1ps
`include "txsw_regs.svh"
module txsw_compose
(
  // request word and event
  input wire logic [15:0] req_word,
  input wire logic eoc,
  input wire logic [1:0] proto_type,
  // results
  output logic [15:0] cmp_word,
  output txsw_pkg::frame_opt_s opts
);
  always_comb
  begin
    // echo all host bits, then force adapter-owned ones
    cmp_word = req_word;
    cmp_word[`SW_FRM_CMP] = 1'b1;
    cmp_word[`SW_EOC] = eoc;
    // reserved field reads back zero in completion form
    cmp_word[`SW_RSV_HI:`SW_RSV_LO] = '0;
    // bit 14 and the other ignored bits never steer anything
    opts.crc_append = ~req_word[`SW_PASS_CRC];
    opts.prio_en = (proto_type == `PROTO_PRIO_A) ||
                   (proto_type == `PROTO_PRIO_B);
    opts.prio = opts.prio_en ?
                req_word[`SW_PRIO_HI:`SW_PRIO_LO] : 3'h0;
  end
endmodule

/* txsw_host_model.sv */
`timescale 1ns/1ps
module txsw_host_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // completion write port
  input wire logic sw_wr_valid,
  input wire logic [15:0] sw_wr_data,
  output logic sw_wr_ready,
  // pacing and stored word
  input wire logic slow,
  output logic [15:0] mem_word
);
  logic [1:0] wait_reg;
  // slow memory holds a write off for three cycles
  assign sw_wr_ready = !slow || wait_reg == 2'h3;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_reg <= 2'h0;
      mem_word <= 16'h0000;
    end
    else if (sw_wr_valid && sw_wr_ready)
    begin
      wait_reg <= 2'h0;
      mem_word <= sw_wr_data;
    end
    else if (sw_wr_valid)
      wait_reg <= wait_reg + 2'h1;
  end
endmodule

/* txsw_pkg.sv */
package txsw_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_read = 3'b001,
    st_move = 3'b010,
    st_write = 3'b011,
    st_stop = 3'b100
  } sw_state_e;

  typedef struct packed {
    logic [15:0] word;
    logic valid;
  } sw_bus_s;

  typedef struct packed {
    logic crc_append;
    logic prio_en;
    logic [2:0] prio;
  } frame_opt_s;
endpackage

/* txsw_regs.svh */
`ifndef TXSW_REGS_SVH
`define TXSW_REGS_SVH
// status word field positions
`define SW_B15 15
`define SW_FRM_CMP 14
`define SW_B13 13
`define SW_B12 12
`define SW_EOC 11
`define SW_B10 10
`define SW_PASS_CRC 9
`define SW_B8 8
`define SW_RSV_HI 7
`define SW_RSV_LO 3
`define SW_PRIO_HI 2
`define SW_PRIO_LO 0
// protocol types that carry priority
`define PROTO_PRIO_A 2'h2
`define PROTO_PRIO_B 2'h3
// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STAT 12'h004
`define OFF_INT_STAT 12'h008
`define OFF_INT_CLR 12'h00C
`define OFF_INT_EN 12'h010
`define OFF_LAST_SW 12'h014
// interrupt bit positions
`define INT_FRM 0
`define INT_EOC 1
`define INT_W 2
// reset values
`define CTRL_RST 32'h0000_0000
`endif

/* txsw_top.sv */
// Function
// - bit 15 ignored on read, echoed back in completion word
// - pass-CRC set: last four bytes sent as check sequence, unchecked
// - pass-CRC clear: adapter generates and appends check sequence
// - protocol 2 or 3: priority driven on upper three tx data lines
// - other protocols: priority field unused
// - after frame enters FIFO, write word with frame-complete set
// - end-of-chain bit set regardless of interrupt enable
// - bits 13,12,10,9,8 and priority echoed unchanged
// - zero forward pointer: raise end-of-chain and stop after status
// - adapter overwrites same word location the host wrote
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "txsw_regs.svh"
module txsw_top
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // list engine side: request word fetched from the list
  input wire logic req_valid,
  input wire logic [15:0] req_word,
  input wire logic fwd_ptr_zero,
  // frame mover: pulse when last byte entered the FIFO
  input wire logic frame_in_fifo,
  // memory write port for the status word location
  output logic sw_wr_valid,
  output logic [15:0] sw_wr_data,
  input wire logic sw_wr_ready,
  // per-frame options to the mac
  output logic crc_append,
  output logic [2:0] phy_tx_nibble_lines,
  output logic prio_valid,
  // channel state and interrupt
  output logic chan_stopped,
  output logic irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    txsw_pkg::sw_state_e st;
    logic [15:0] req;
    logic last;
    txsw_pkg::sw_bus_s wr;
    logic [15:0] last_sw;
    logic [1:0] proto;
    logic [`INT_W-1:0] int_stat;
    logic [`INT_W-1:0] int_en;
    logic stopped;
    logic crc_append;
    logic [2:0] prio;
    logic prio_valid;
    logic [31:0] rdata;
  } state_s;

  state_s s_reg;
  state_s s_next;
  logic [15:0] cmp_word;
  txsw_pkg::frame_opt_s opts;
  logic wr_acc;
  logic rd_acc;

  txsw_compose u_compose
  (
    .req_word(s_reg.req),
    .eoc(s_reg.last),
    .proto_type(s_reg.proto),
    .cmp_word(cmp_word),
    .opts(opts)
  );

  function automatic logic [31:0] zext16(input logic [15:0] v);
    zext16 = {16'h0000, v};
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic [`INT_W-1:0] ev;
    ev = '0;
    s_next = s_reg;
    wr_acc = psel && penable && pwrite;
    rd_acc = psel && !penable && !pwrite;
    case (s_reg.st)
      txsw_pkg::st_idle:
      begin
        if (req_valid)
        begin
          s_next.req = req_word;
          s_next.last = fwd_ptr_zero;
          s_next.stopped = 1'b0;
          s_next.st = txsw_pkg::st_read;
        end
      end
      txsw_pkg::st_read:
      begin
        // options latched from the request word and protocol type for this frame
        s_next.crc_append = opts.crc_append;
        s_next.prio = opts.prio;
        s_next.prio_valid = opts.prio_en;
        s_next.st = txsw_pkg::st_move;
      end
      txsw_pkg::st_move:
      begin
        // status waits for the last byte in the FIFO
        if (frame_in_fifo)
        begin
          s_next.wr.word = cmp_word;
          s_next.wr.valid = 1'b1;
          s_next.st = txsw_pkg::st_write;
        end
      end
      txsw_pkg::st_write:
      begin
        if (sw_wr_ready)
        begin
          s_next.wr.valid = 1'b0;
          s_next.last_sw = s_reg.wr.word;
          s_next.prio_valid = 1'b0;
          // priority lines fall idle with their qualifier
          s_next.prio = 3'h0;
          ev[`INT_FRM] = 1'b1;
          if (s_reg.last)
          begin
            ev[`INT_EOC] = 1'b1;
            s_next.stopped = 1'b1;
            s_next.st = txsw_pkg::st_stop;
          end
          else
          begin
            s_next.st = txsw_pkg::st_idle;
          end
        end
      end
      txsw_pkg::st_stop:
      begin
        // channel stays stopped until a new request arrives
        if (req_valid)
        begin
          s_next.req = req_word;
          s_next.last = fwd_ptr_zero;
          s_next.stopped = 1'b0;
          s_next.st = txsw_pkg::st_read;
        end
      end
      default:
      begin
        s_next.st = txsw_pkg::st_idle;
      end
    endcase

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    if (wr_acc)
    begin
      case (paddr)
        `OFF_CTRL: s_next.proto = pwdata[1:0];
        `OFF_INT_EN: s_next.int_en = pwdata[`INT_W-1:0];
        `OFF_INT_CLR:
          s_next.int_stat = s_reg.int_stat & ~pwdata[`INT_W-1:0];
        default: ;
      endcase
    end
    // set wins over a same-cycle clear
    s_next.int_stat = s_next.int_stat | ev;

    if (rd_acc)
    begin
      case (paddr)
        `OFF_CTRL: s_next.rdata = {30'h0, s_reg.proto};
        `OFF_STAT: s_next.rdata = {28'h0, s_reg.stopped, s_reg.st};
        `OFF_INT_STAT: s_next.rdata = {30'h0, s_reg.int_stat};
        `OFF_INT_EN: s_next.rdata = {30'h0, s_reg.int_en};
        `OFF_LAST_SW: s_next.rdata = zext16(s_reg.last_sw);
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.st <= txsw_pkg::st_idle;
      s_reg.crc_append <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata = s_reg.rdata;
  // no wait states; read data registered in setup
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign sw_wr_valid = s_reg.wr.valid;
  assign sw_wr_data = s_reg.wr.word;
  assign crc_append = s_reg.crc_append;
  assign phy_tx_nibble_lines = s_reg.prio;
  assign prio_valid = s_reg.prio_valid;
  assign chan_stopped = s_reg.stopped;
  assign irq = |(s_reg.int_stat & s_reg.int_en);
endmodule

/* txsw_top_properties.sv */
`timescale 1ns/1ps
module txsw_top_properties
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // observed dut inputs and outputs
  input wire logic frame_in_fifo,
  input wire logic sw_wr_valid,
  input wire logic [15:0] sw_wr_data,
  input wire logic sw_wr_ready,
  input wire logic crc_append,
  input wire logic [2:0] phy_tx_nibble_lines,
  input wire logic prio_valid,
  input wire logic chan_stopped
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  write_cause_a: assert property ($rose(sw_wr_valid) |-> $past(frame_in_fifo))
    else $error("completion write without frame");
  write_hold_a: assert property (sw_wr_valid && !sw_wr_ready |=>
    sw_wr_valid && $stable(sw_wr_data)) else $error("write dropped");
  frame_bit_a: assert property (sw_wr_valid |-> sw_wr_data[14])
    else $error("frame bit clear");
  crc_opt_a: assert property (sw_wr_valid |-> crc_append == !sw_wr_data[9])
    else $error("crc option wrong");
  prio_out_a: assert property (sw_wr_valid && prio_valid |->
    phy_tx_nibble_lines == sw_wr_data[2:0]) else $error("priority wrong");
  prio_off_a: assert property (!prio_valid |-> phy_tx_nibble_lines == 3'h0)
    else $error("priority unused but driven");
  chain_stop_a: assert property (sw_wr_valid && sw_wr_ready &&
    sw_wr_data[11] |=> chan_stopped) else $error("no stop");
  chain_bit_a: assert property ($rose(chan_stopped) |-> $past(sw_wr_data[11]))
    else $error("stop without end bit");
endmodule
bind txsw_top txsw_top_properties u_props (.pclk(pclk), .presetn(presetn),
  .frame_in_fifo(frame_in_fifo), .sw_wr_valid(sw_wr_valid),
  .sw_wr_data(sw_wr_data), .sw_wr_ready(sw_wr_ready),
  .crc_append(crc_append), .phy_tx_nibble_lines(phy_tx_nibble_lines),
  .prio_valid(prio_valid), .chan_stopped(chan_stopped));
